// ### pkg/link_ctl_defines.svh
// constants for the exchange-side multi-link controller
// assumes a 250 MHz core clock and 2 048 kbit/s links of 32 slots
`ifndef LINK_CTL_DEFINES_SVH
`define LINK_CTL_DEFINES_SVH

`define LC_NUM_LINKS 16
`define LC_LINK_W 4
`define LC_SLOT_W 5
`define LC_CCHAN_SLOT 5'h10
`define LC_FRAME_SLOT 5'h00
`define LC_LAST_SLOT 6'h1f
`define LC_ID_W 8
`define LC_ID_BITS 3'h7
// arbitrary tag ahead of the link number in the identity word
`define LC_ID_TAG 4'ha
`define LC_CORE_PERIOD_NS 4
`define LC_CHECK_TIMEOUT_NS 4000
`define LC_CHECK_TIMEOUT_CYC (`LC_CHECK_TIMEOUT_NS / `LC_CORE_PERIOD_NS)
`define LC_TMO_W 10
`define LC_MIGRATE_NS 2000
`define LC_MIGRATE_CYC (`LC_MIGRATE_NS / `LC_CORE_PERIOD_NS)
`define LC_MIG_W 9
`define LC_RECHECK_US 1000
`define LC_RECHECK_CYC (`LC_RECHECK_US * 1000 / `LC_CORE_PERIOD_NS)
`define LC_RCHK_W 18

`endif

// ### pkg/link_ctl_pkg.sv
// types shared by the link controller modules
// assumes link_ctl_defines.svh holds all numbers
package link_ctl_pkg;

    typedef enum logic [2:0] {
        CHK_IDLE = 3'b001,
        CHK_RUN = 3'b010,
        CHK_DONE = 3'b100
    } chk_state_t;

    typedef enum logic [3:0] {
        BLK_IDLE = 4'b0001,
        BLK_REL = 4'b0010,
        BLK_WAIT = 4'b0100,
        BLK_MIG = 4'b1000
    } blk_state_t;

endpackage : link_ctl_pkg

// ### rtl/link_id_check.sv
// serial identity exchange with the access side over one link
// assumes link_clk and id_rx are pins from outside the core domain
`timescale 1ns/10ps
`include "link_ctl_defines.svh"

module link_id_check
    import link_ctl_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [`LC_ID_W-1:0] tx_word,
    input wire logic link_clk,
    input wire logic id_rx,
    output logic id_tx,
    output logic busy,
    output logic done,
    output logic pass
);
    logic lclk_s1_r, lclk_s2_r, lclk_s3_r, lclk_st_r;
    logic rx_s1_r, rx_s2_r, rx_s3_r, rx_st_r;
    logic [`LC_ID_W-1:0] tx_sh_r, rx_sh_r, exp_r;
    logic [2:0] bit_cnt_r;
    logic [`LC_TMO_W-1:0] tmo_cnt_r;
    logic bits_ok_r, id_tx_r, done_r, pass_r;
    chk_state_t state_r, state_nxt;

    wire lclk_agree = lclk_s2_r == lclk_s3_r;
    wire lclk_rise = lclk_agree & lclk_s3_r & ~lclk_st_r;
    wire lclk_fall = lclk_agree & ~lclk_s3_r & lclk_st_r;
    wire last_bit = lclk_rise && bit_cnt_r == `LC_ID_BITS;
    wire tmo_hit = tmo_cnt_r == `LC_TMO_W'(`LC_CHECK_TIMEOUT_CYC - 1);
    wire in_run = state_r == CHK_RUN;

    always_comb begin
        case (state_r)
            CHK_IDLE: state_nxt = start ? CHK_RUN : CHK_IDLE;
            CHK_RUN: state_nxt = (last_bit || tmo_hit) ? CHK_DONE : CHK_RUN;
            CHK_DONE: state_nxt = CHK_IDLE;
            default: state_nxt = CHK_IDLE;
        endcase
    end

    // pin synchronisers: a change counts once stages two and three agree
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            {lclk_s1_r, lclk_s2_r, lclk_s3_r, lclk_st_r} <= 4'h0;
            {rx_s1_r, rx_s2_r, rx_s3_r, rx_st_r} <= 4'h0;
        end else begin
            {lclk_s1_r, lclk_s2_r, lclk_s3_r} <= {link_clk, lclk_s1_r, lclk_s2_r};
            {rx_s1_r, rx_s2_r, rx_s3_r} <= {id_rx, rx_s1_r, rx_s2_r};
            if (lclk_agree) lclk_st_r <= lclk_s3_r;
            if (rx_s2_r == rx_s3_r) rx_st_r <= rx_s3_r;
        end
    end

    // word goes out msb first on falling edges, comes in on rising edges
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r <= CHK_IDLE;
            tx_sh_r <= 8'h00;
            rx_sh_r <= 8'h00;
            exp_r <= 8'h00;
            bit_cnt_r <= 3'h0;
            bits_ok_r <= 1'b0;
            id_tx_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (start && state_r == CHK_IDLE) begin
                tx_sh_r <= tx_word;
                exp_r <= tx_word;
                id_tx_r <= tx_word[`LC_ID_W-1];
                bit_cnt_r <= 3'h0;
                bits_ok_r <= 1'b0;
            end else if (in_run && lclk_rise) begin
                rx_sh_r <= {rx_sh_r[`LC_ID_W-2:0], rx_st_r};
                tx_sh_r <= {tx_sh_r[`LC_ID_W-2:0], 1'b0};
                bit_cnt_r <= bit_cnt_r + 3'h1;
                bits_ok_r <= last_bit;
            end else if (in_run && lclk_fall) begin
                id_tx_r <= tx_sh_r[`LC_ID_W-1];
            end
        end
    end

    // a stopped link clock ends the check as a failure
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tmo_cnt_r <= `LC_TMO_W'(0);
            done_r <= 1'b0;
            pass_r <= 1'b0;
        end else begin
            tmo_cnt_r <= (in_run && !lclk_rise) ? tmo_cnt_r + `LC_TMO_W'(1)
                                                : `LC_TMO_W'(0);
            done_r <= state_r == CHK_DONE;
            if (state_r == CHK_DONE)
                pass_r <= bits_ok_r && rx_sh_r == exp_r; // RULE_13
        end
    end

    assign id_tx = id_tx_r;
    assign busy = state_r != CHK_IDLE;
    assign done = done_r;
    assign pass = pass_r;

    AST_CHK_PASS_MATCH: assert property ( // RULE_13
        @(posedge core_clk) disable iff (rst)
        done_r && pass_r |-> $past(rx_sh_r == exp_r) && $past(bits_ok_r))
        else $error("identity passed without a matching word");

endmodule : link_id_check

// ### rtl/link_ctl_host.sv
// exchange-side controller for a multi-link access interface
// assumes the message layer hands requests in as core_clk pulses
// and that l1_normal, link_clk and id_rx arrive asynchronously
//
// Contract
// RULE_01: one to sixteen links, chosen by link_en, form one interface.
// RULE_02: each communication channel is one 64 kbit/s slot of a link.
// RULE_03: slot 16 of primary, and secondary when multi-link, is a C-channel.
// RULE_04: a C-channel slot is never granted to bearer traffic.
// RULE_05: bearer grants cover one slot or a run of several slots.
// RULE_06: an active C-channel that stops carrying traffic becomes standby.
// RULE_07: a standby C-channel put into use becomes active.
// RULE_08: at start primary slot 16 carries protection, control, bearer paths.
// RULE_09: at start secondary slot 16 carries protection and stands by.
// RULE_10: logical channel groups distinct paths, never the protection path.
// RULE_11: protection group is N active plus K standby C-channels.
// RULE_12: identity check starts when a link's layer 1 enters normal.
// RULE_13: a failed identity check sends layer 1 back to non-operational.
// RULE_14: every link is checked, primary and secondary included.
// RULE_15: the check may repeat on a timer or on management request.
// RULE_16: access side only asks to block; the exchange decides.
// RULE_17: accepted block releases switched, later moves fixed connections.
// RULE_18: a blocked link's logical channels move via protection.
// RULE_19: access side may block at once on internal failure.
// RULE_20: immediate block comes with protection switching where possible.
// RULE_21: blocking the only link takes the whole interface down.
// RULE_22: a blocked link's slots get no new bearer grants.
`timescale 1ns/10ps
`include "link_ctl_defines.svh"

module link_ctl_host
    import link_ctl_pkg::*;
#(
    parameter int unsigned RECHECK_CYCLES = `LC_RECHECK_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [`LC_NUM_LINKS-1:0] link_en,
    input wire logic [`LC_LINK_W-1:0] primary_link,
    input wire logic [`LC_LINK_W-1:0] secondary_link,
    input wire logic [`LC_NUM_LINKS-1:0] l1_normal,
    output logic [`LC_NUM_LINKS-1:0] l1_deact,
    output logic [`LC_NUM_LINKS-1:0] link_ok,
    input wire logic link_clk,
    input wire logic id_rx,
    output logic id_tx,
    input wire logic mgmt_chk,
    input wire logic [`LC_LINK_W-1:0] mgmt_chk_link,
    input wire logic blk_req,
    input wire logic [`LC_LINK_W-1:0] blk_link,
    input wire logic blk_accept,
    input wire logic imm_blk,
    input wire logic [`LC_LINK_W-1:0] imm_link,
    input wire logic unblk,
    input wire logic [`LC_LINK_W-1:0] unblk_link,
    output logic blk_ack,
    output logic blk_grant,
    output logic [`LC_LINK_W-1:0] blk_out_link,
    output logic rel_sw,
    output logic mig,
    output logic [`LC_NUM_LINKS-1:0] blocked,
    output logic prot_sw,
    output logic [`LC_LINK_W-1:0] prot_link,
    output logic pri_active,
    output logic sec_active,
    output logic [`LC_LINK_W-1:0] lch_link,
    input wire logic alloc_req,
    input wire logic [`LC_LINK_W-1:0] alloc_link,
    input wire logic [`LC_SLOT_W-1:0] alloc_slot,
    input wire logic [`LC_SLOT_W-1:0] alloc_cnt,
    output logic alloc_done,
    output logic alloc_ok,
    output logic in_svc
);
    localparam int MIG_DLY = `LC_MIGRATE_CYC + 1;

    function automatic logic [`LC_LINK_W-1:0] lowest(
        input logic [`LC_NUM_LINKS-1:0] v
    );
        logic [`LC_LINK_W-1:0] idx;
        idx = `LC_LINK_W'(0);
        for (int i = `LC_NUM_LINKS - 1; i >= 0; i--)
            if (v[i]) idx = `LC_LINK_W'(i);
        return idx;
    endfunction : lowest

    logic [`LC_NUM_LINKS-1:0] norm_s1_r, norm_s2_r, norm_s3_r, norm_st_r;
    logic [`LC_NUM_LINKS-1:0] pending_r, ok_r, deact_r, blocked_r;
    logic [`LC_LINK_W-1:0] cur_link_r, blk_out_link_r, prot_link_r;
    logic [`LC_LINK_W-1:0] lch_link_r;
    logic [`LC_RCHK_W-1:0] rchk_cnt_r;
    logic [`LC_MIG_W-1:0] mig_cnt_r;
    logic blk_ack_r, blk_grant_r, rel_sw_r, mig_r, prot_sw_r;
    logic act_primary_r, alloc_done_r, alloc_ok_r, in_svc_r;
    logic chk_busy, chk_done, chk_pass;
    blk_state_t blk_state_r, blk_state_nxt;

    // layer 1 normal pins: a change counts once stages two and three agree
    wire [`LC_NUM_LINKS-1:0] norm_agree = ~(norm_s2_r ^ norm_s3_r);
    wire [`LC_NUM_LINKS-1:0] norm_rise = norm_agree & norm_s3_r & ~norm_st_r;
    wire [`LC_NUM_LINKS-1:0] norm_st_nxt =
        (norm_agree & norm_s3_r) | (~norm_agree & norm_st_r);

    // more than one enabled link makes the secondary exist
    wire multi = (link_en & (link_en - `LC_NUM_LINKS'(1))) != '0; // RULE_01

    // identity scheduling
    wire rchk_tick = rchk_cnt_r == `LC_RCHK_W'(RECHECK_CYCLES - 1);
    wire [`LC_NUM_LINKS-1:0] rchk_set = // RULE_15
        rchk_tick ? (norm_st_r & ok_r) : '0;
    wire [`LC_NUM_LINKS-1:0] mgmt_set = // RULE_15
        mgmt_chk ? (`LC_NUM_LINKS'(1) << mgmt_chk_link) : '0;
    wire [`LC_NUM_LINKS-1:0] pend_set = (norm_rise & link_en) // RULE_12
        | rchk_set | mgmt_set;
    wire [`LC_LINK_W-1:0] sel_link = lowest(pending_r);
    wire chk_start = (pending_r != '0) && !chk_busy && !chk_done; // RULE_14
    wire [`LC_NUM_LINKS-1:0] pend_clr =
        chk_start ? (`LC_NUM_LINKS'(1) << sel_link) : '0;
    wire [`LC_NUM_LINKS-1:0] pending_nxt = ((pending_r & ~pend_clr)
        | pend_set) & link_en & (norm_st_r | norm_rise);
    wire [`LC_NUM_LINKS-1:0] cur_hot = `LC_NUM_LINKS'(1) << cur_link_r;
    wire chk_fail = chk_done && !chk_pass;
    wire [`LC_NUM_LINKS-1:0] fail_set = chk_fail ? cur_hot : '0; // RULE_13
    wire [`LC_NUM_LINKS-1:0] pass_set = (chk_done && chk_pass) ? cur_hot : '0;
    wire [`LC_NUM_LINKS-1:0] ok_nxt = (ok_r & ~fail_set & norm_st_nxt)
        | (pass_set & norm_st_nxt);

    // blocking: the exchange takes the decision
    wire blk_take = blk_req && blk_state_r == BLK_IDLE;
    wire blk_yes = blk_take && blk_accept && link_en[blk_link]; // RULE_16
    wire imm_valid = imm_blk && link_en[imm_link]; // RULE_19
    wire [`LC_NUM_LINKS-1:0] blk_set =
        blk_yes ? (`LC_NUM_LINKS'(1) << blk_link) : '0;
    wire [`LC_NUM_LINKS-1:0] imm_set =
        imm_valid ? (`LC_NUM_LINKS'(1) << imm_link) : '0;
    wire [`LC_NUM_LINKS-1:0] unblk_set =
        unblk ? (`LC_NUM_LINKS'(1) << unblk_link) : '0;
    wire [`LC_NUM_LINKS-1:0] blocked_nxt = // RULE_22
        (blocked_r & ~unblk_set) | blk_set | imm_set;
    wire mig_last = mig_cnt_r == `LC_MIG_W'(`LC_MIGRATE_CYC - 1);

    // protection: one logical channel on slot 16, one standby slot 16
    wire [`LC_LINK_W-1:0] act_link =
        act_primary_r ? primary_link : secondary_link;
    wire [`LC_LINK_W-1:0] sby_link =
        act_primary_r ? secondary_link : primary_link;
    wire sby_ok = multi && link_en[sby_link] && !blocked_r[sby_link]; // RULE_11
    wire prot_trig = imm_valid || chk_fail || blk_state_r == BLK_REL;
    wire [`LC_LINK_W-1:0] prot_src = imm_valid ? imm_link // RULE_20
        : chk_fail ? cur_link_r : blk_out_link_r; // RULE_18
    wire swap = prot_trig && prot_src == act_link && sby_ok; // RULE_06

    // bearer grants avoid framing slot, C-channels and blocked links
    wire [5:0] alloc_last = {1'b0, alloc_slot} + {1'b0, alloc_cnt} - 6'h01;
    wire cchan_link = alloc_link == primary_link // RULE_03
        || (multi && alloc_link == secondary_link);
    wire hits16 = alloc_slot <= `LC_CCHAN_SLOT // RULE_02
        && alloc_last >= {1'b0, `LC_CCHAN_SLOT};
    wire range_ok = alloc_cnt != `LC_SLOT_W'(0) // RULE_05
        && alloc_last <= `LC_LAST_SLOT && alloc_slot != `LC_FRAME_SLOT;
    wire alloc_fit = range_ok && !(cchan_link && hits16) // RULE_04
        && link_en[alloc_link] && ok_r[alloc_link]
        && !blocked_r[alloc_link]; // RULE_22

    always_comb begin
        case (blk_state_r)
            BLK_IDLE: blk_state_nxt = blk_yes ? BLK_REL : BLK_IDLE;
            BLK_REL: blk_state_nxt = BLK_WAIT;
            BLK_WAIT: blk_state_nxt = mig_last ? BLK_MIG : BLK_WAIT;
            BLK_MIG: blk_state_nxt = BLK_IDLE;
            default: blk_state_nxt = BLK_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            norm_s1_r <= '0;
            norm_s2_r <= '0;
            norm_s3_r <= '0;
            norm_st_r <= '0;
        end else begin
            norm_s1_r <= l1_normal;
            norm_s2_r <= norm_s1_r;
            norm_s3_r <= norm_s2_r;
            norm_st_r <= norm_st_nxt;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pending_r <= '0;
            ok_r <= '0;
            deact_r <= '0;
            cur_link_r <= `LC_LINK_W'(0);
            rchk_cnt_r <= `LC_RCHK_W'(0);
        end else begin
            pending_r <= pending_nxt;
            ok_r <= ok_nxt;
            deact_r <= fail_set; // RULE_13
            if (chk_start) cur_link_r <= sel_link;
            rchk_cnt_r <= rchk_tick ? `LC_RCHK_W'(0)
                                    : rchk_cnt_r + `LC_RCHK_W'(1);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            blk_state_r <= BLK_IDLE;
            blk_ack_r <= 1'b0;
            blk_grant_r <= 1'b0;
            blk_out_link_r <= `LC_LINK_W'(0);
            rel_sw_r <= 1'b0;
            mig_r <= 1'b0;
            mig_cnt_r <= `LC_MIG_W'(0);
            blocked_r <= '0;
        end else begin
            blk_state_r <= blk_state_nxt;
            blk_ack_r <= blk_req;
            blk_grant_r <= blk_yes; // RULE_16
            if (blk_yes) blk_out_link_r <= blk_link;
            rel_sw_r <= blk_state_r == BLK_REL; // RULE_17
            mig_r <= blk_state_r == BLK_MIG; // RULE_17
            mig_cnt_r <= (blk_state_r == BLK_WAIT && !mig_last)
                ? mig_cnt_r + `LC_MIG_W'(1) : `LC_MIG_W'(0);
            blocked_r <= blocked_nxt;
        end
    end

    // primary slot 16 starts active, secondary slot 16 starts as standby
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            act_primary_r <= 1'b1; // RULE_08
            prot_sw_r <= 1'b0;
            prot_link_r <= `LC_LINK_W'(0);
            lch_link_r <= `LC_LINK_W'(0);
            alloc_done_r <= 1'b0;
            alloc_ok_r <= 1'b0;
            in_svc_r <= 1'b0;
        end else begin
            if (swap) act_primary_r <= ~act_primary_r; // RULE_07
            prot_sw_r <= swap;
            if (swap) prot_link_r <= sby_link; // RULE_09
            lch_link_r <= swap ? sby_link : act_link; // RULE_10
            alloc_done_r <= alloc_req;
            if (alloc_req) alloc_ok_r <= alloc_fit;
            in_svc_r <= (link_en & ~blocked_r & ok_r) != '0; // RULE_21
        end
    end

    link_id_check u_chk (
        .core_clk(core_clk),
        .rst(rst),
        .start(chk_start),
        .tx_word({`LC_ID_TAG, sel_link}),
        .link_clk(link_clk),
        .id_rx(id_rx),
        .id_tx(id_tx),
        .busy(chk_busy),
        .done(chk_done),
        .pass(chk_pass)
    );

    assign l1_deact = deact_r;
    assign link_ok = ok_r;
    assign blk_ack = blk_ack_r;
    assign blk_grant = blk_grant_r;
    assign blk_out_link = blk_out_link_r;
    assign rel_sw = rel_sw_r;
    assign mig = mig_r;
    assign blocked = blocked_r;
    assign prot_sw = prot_sw_r;
    assign prot_link = prot_link_r;
    assign pri_active = act_primary_r;
    assign sec_active = multi & ~act_primary_r;
    assign lch_link = lch_link_r;
    assign alloc_done = alloc_done_r;
    assign alloc_ok = alloc_ok_r;
    assign in_svc = in_svc_r;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    AST_CCHAN_NO_BEARER: assert property ( // RULE_04
        alloc_req && cchan_link && hits16 |=> alloc_done_r && !alloc_ok_r)
        else $error("bearer grant landed on a C-channel slot");
    AST_BLOCKED_NO_ALLOC: assert property ( // RULE_22
        alloc_req && blocked_r[alloc_link] |=> !alloc_ok_r)
        else $error("bearer grant on a blocked link");
    AST_FAIL_DEACT: assert property ( // RULE_13
        chk_done && !chk_pass |=> deact_r[$past(cur_link_r)]
            && !ok_r[$past(cur_link_r)])
        else $error("failed check left layer 1 operational");
    AST_NORMAL_CHECK: assert property ( // RULE_12
        norm_rise[0] && link_en[0] |=> pending_r[0])
        else $error("entry to normal did not queue a check");
    AST_CHECK_EVERY_LINK: assert property ( // RULE_14
        (norm_rise & link_en) != '0 |=> (pending_r & $past(norm_rise
            & link_en)) == $past(norm_rise & link_en))
        else $error("a link entering normal was not queued for a check");
    AST_SVC_DOWN: assert property ( // RULE_21
        (link_en & ~blocked_r) == '0 |=> !in_svc_r)
        else $error("interface in service with every link blocked");
    AST_ONE_ACTIVE: assert property ( // RULE_06
        multi |-> pri_active ^ sec_active)
        else $error("slot 16 roles not one active one standby");
    AST_LCH_ON_ACTIVE: assert property ( // RULE_06
        !$past(rst) |-> lch_link_r == act_link)
        else $error("logical channel not on the active slot 16");
    AST_SWAP_ROLES: assert property ( // RULE_07
        swap |=> act_primary_r != $past(act_primary_r) && prot_sw_r)
        else $error("protection switch did not swap roles");
    AST_RELEASE_FIRST: assert property ( // RULE_17
        blk_ack_r && blk_grant_r |=> rel_sw_r ##[MIG_DLY:MIG_DLY] mig_r)
        else $error("release and migration out of order");
    AST_IMM_BLOCK: assert property ( // RULE_19
        imm_valid |=> blocked_r[$past(imm_link)])
        else $error("immediate block not applied");
    AST_INIT_PRIMARY: assert property ( // RULE_08
        $fell(rst) |-> act_primary_r)
        else $error("secondary active straight after reset");

endmodule : link_ctl_host

// ### test/access_side_model.sv
// access-side identity responder for one link at a time
// assumes the bench raises go once the controller has started a check
`timescale 1ns/10ps
`include "link_ctl_defines.svh"

module access_side_model (
    input wire logic go,
    input wire logic [`LC_ID_W-1:0] word,
    input wire logic id_tx,
    output logic link_clk,
    output logic id_rx,
    output logic [`LC_ID_W-1:0] heard
);
    logic [`LC_ID_W-1:0] sh;
    logic last;

    // clock stands low between frames, data released as inverse of last bit
    initial begin
        link_clk = 1'b0;
        id_rx = 1'b1;
        heard = '0;
        sh = '0;
        last = 1'b0;
        forever begin
            @(posedge go);
            #1.3;
            sh = word;
            id_rx = sh[`LC_ID_W-1];
            repeat (`LC_ID_W) begin
                #16 link_clk = 1'b1;
                heard = {heard[`LC_ID_W-2:0], id_tx};
                #16 link_clk = 1'b0;
                last = id_rx;
                sh = sh << 1;
                id_rx = sh[`LC_ID_W-1];
            end
            id_rx = ~last;
        end
    end
endmodule : access_side_model

// ### test/testbench.sv
// self-checking bench for the exchange-side link controller
// assumes access_side_model answers identity frames on request
`timescale 1ns/10ps
`include "link_ctl_defines.svh"

module testbench;
    logic core_clk, rst, link_clk, id_rx, id_tx, peer_go;
    logic [`LC_NUM_LINKS-1:0] link_en, l1_normal, l1_deact, link_ok, blocked;
    logic [`LC_LINK_W-1:0] primary_link, secondary_link, mgmt_chk_link;
    logic [`LC_LINK_W-1:0] blk_link, imm_link, unblk_link, alloc_link;
    logic [`LC_LINK_W-1:0] blk_out_link, prot_link, lch_link;
    logic mgmt_chk, blk_req, blk_accept, imm_blk, unblk, alloc_req;
    logic blk_ack, blk_grant, rel_sw, mig, prot_sw, pri_active, sec_active;
    logic alloc_done, alloc_ok, in_svc;
    logic [`LC_SLOT_W-1:0] alloc_slot, alloc_cnt;
    logic [`LC_ID_W-1:0] peer_word, peer_heard;
    int err_total, compares, cyc;

    link_ctl_host #(.RECHECK_CYCLES(50000)) u_dut (.core_clk(core_clk),
        .rst(rst), .link_en(link_en), .primary_link(primary_link),
        .secondary_link(secondary_link), .l1_normal(l1_normal),
        .l1_deact(l1_deact), .link_ok(link_ok), .link_clk(link_clk),
        .id_rx(id_rx), .id_tx(id_tx), .mgmt_chk(mgmt_chk),
        .mgmt_chk_link(mgmt_chk_link), .blk_req(blk_req),
        .blk_link(blk_link), .blk_accept(blk_accept), .imm_blk(imm_blk),
        .imm_link(imm_link), .unblk(unblk), .unblk_link(unblk_link),
        .blk_ack(blk_ack), .blk_grant(blk_grant),
        .blk_out_link(blk_out_link), .rel_sw(rel_sw), .mig(mig),
        .blocked(blocked), .prot_sw(prot_sw), .prot_link(prot_link),
        .pri_active(pri_active), .sec_active(sec_active),
        .lch_link(lch_link), .alloc_req(alloc_req),
        .alloc_link(alloc_link), .alloc_slot(alloc_slot),
        .alloc_cnt(alloc_cnt), .alloc_done(alloc_done),
        .alloc_ok(alloc_ok), .in_svc(in_svc));

    access_side_model u_peer (.go(peer_go), .word(peer_word),
        .id_tx(id_tx), .link_clk(link_clk), .id_rx(id_rx),
        .heard(peer_heard));

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic end_of_test();
        $display("errors %0d of %0d compares", err_total, compares);
        if (err_total == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            end_of_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask : tick

    // one identity frame; re selects a management recheck
    task automatic id_run(input logic [3:0] n, input logic good,
                          input logic re);
        int i;
        @(negedge core_clk);
        if (re) begin
            mgmt_chk_link = n;
            mgmt_chk = 1'b1;
            @(negedge core_clk);
            mgmt_chk = 1'b0;
        end else l1_normal[n] = 1'b1;
        repeat (20) @(negedge core_clk);
        peer_word = good ? {`LC_ID_TAG, n} : {`LC_ID_TAG, ~n};
        peer_go = 1'b1;
        @(negedge core_clk);
        peer_go = 1'b0;
        for (i = 0; i < 400 && l1_deact[n] !== 1'b1; i++) begin
            if (good && link_ok[n] === 1'b1 && i > 80) break;
            tick();
        end
        chk(l1_deact[n], !good);
        chk(peer_heard, {`LC_ID_TAG, n});
        if (!good) @(negedge core_clk) l1_normal[n] = 1'b0;
        repeat (3) tick();
        chk(link_ok[n], good);
    endtask : id_run

    task automatic blk_try(input logic [3:0] n, input logic acc,
                           input logic g);
        @(negedge core_clk);
        blk_link = n;
        blk_accept = acc;
        blk_req = 1'b1;
        @(negedge core_clk);
        blk_req = 1'b0;
        // ack stands one cycle: look before the next edge
        chk({blk_ack, blk_grant}, {1'b1, g});
        if (g) chk(blocked[n], 1'b1);
    endtask : blk_try

    task automatic alloc_try(input logic [3:0] n, input logic [4:0] s,
                             input logic [4:0] c, input logic ok);
        @(negedge core_clk);
        {alloc_link, alloc_slot, alloc_cnt, alloc_req} = {n, s, c, 1'b1};
        @(negedge core_clk);
        alloc_req = 1'b0;
        chk({alloc_done, alloc_ok}, {1'b1, ok});
    endtask : alloc_try

    task automatic block_scenario();
        int i;
        blk_try(4'h1, 1'b0, 1'b0);
        blk_try(4'h1, 1'b1, 1'b1);
        tick();
        chk({rel_sw, blk_out_link}, {1'b1, 4'h1});
        blk_try(4'h0, 1'b1, 1'b0);
        for (i = 0; i < 600 && mig !== 1'b1; i++) tick();
        chk(i, `LC_MIGRATE_CYC);
        alloc_try(4'h1, 5'h01, 5'h01, 1'b0);
        @(negedge core_clk);
        {unblk_link, unblk} = {4'h1, 1'b1};
        @(negedge core_clk);
        unblk = 1'b0;
        repeat (3) tick();
        chk(blocked[1], 1'b0);
        alloc_try(4'h1, 5'h01, 5'h01, 1'b1);
    endtask : block_scenario

    task automatic imm_hit(input logic [3:0] n);
        @(negedge core_clk);
        {imm_link, imm_blk} = {n, 1'b1};
        @(negedge core_clk);
        imm_blk = 1'b0;
    endtask : imm_hit

    task automatic imm_scenario();
        imm_hit(4'h0);
        chk({blocked[0], prot_sw, prot_link}, {2'b11, 4'h1});
        tick();
        chk({pri_active, sec_active, lch_link}, {2'b01, 4'h1});
        chk(in_svc, 1'b1);
        imm_hit(4'h1);
        chk(prot_sw, 1'b0);
        repeat (3) tick();
        chk(in_svc, 1'b0);
        imm_hit(4'h2);
        tick();
        chk(blocked, 16'h0007);
    endtask : imm_scenario

    initial begin
        {rst, peer_go, mgmt_chk, blk_req, blk_accept, imm_blk} = 6'h20;
        {unblk, alloc_req, mgmt_chk_link, blk_link} = '0;
        {imm_link, unblk_link, alloc_link, alloc_slot, alloc_cnt} = '0;
        {link_en, l1_normal, peer_word} = {16'h0007, 16'h0000, 8'h00};
        {primary_link, secondary_link, err_total, compares, cyc} = '0;
        secondary_link = 4'h1;
        repeat (12) @(negedge core_clk);
        rst = 1'b0;
        tick();
        chk({pri_active, sec_active, blocked}, {2'b10, 16'h0000});
        chk({link_ok, in_svc}, 17'h00000);
        id_run(4'h0, 1'b1, 1'b0);
        id_run(4'h1, 1'b1, 1'b0);
        id_run(4'h2, 1'b0, 1'b0);
        id_run(4'h1, 1'b1, 1'b1);
        chk(in_svc, 1'b1);
        alloc_try(4'h0, 5'h01, 5'h02, 1'b1);
        alloc_try(4'h0, 5'h10, 5'h01, 1'b0);
        alloc_try(4'h0, 5'h0f, 5'h02, 1'b0);
        alloc_try(4'h1, 5'h10, 5'h01, 1'b0);
        alloc_try(4'h0, 5'h11, 5'h0f, 1'b1);
        alloc_try(4'h0, 5'h11, 5'h10, 1'b0);
        alloc_try(4'h0, 5'h01, 5'h00, 1'b0);
        alloc_try(4'h2, 5'h01, 5'h01, 1'b0);
        block_scenario();
        imm_scenario();
        end_of_test();
    end
endmodule : testbench
